// *** hdl/hpb_pkg.sv ***
package hpb_pkg;
  localparam int unsigned HPB_ADDR_W = 3;
  localparam int unsigned HPB_DATA_W = 8;
  localparam int unsigned HPB_NUM_REGS = 8;
  localparam logic [7:0] HPB_REG_RESET = 8'h00;
  // Host strobe phase lengths, in clk_sys cycles
  localparam int unsigned HPB_SETUP_CYC = 1;
  localparam int unsigned HPB_PULSE_CYC = 3;
  localparam int unsigned HPB_HOLD_CYC = 1;
  localparam logic [1:0] HPB_CNT_W_ZERO = 2'h0;

  typedef enum logic [2:0] {
    HPB_H_IDLE = 3'b000,
    HPB_H_SETUP = 3'b001,
    HPB_H_PULSE = 3'b010,
    HPB_H_HOLD = 3'b011,
    HPB_H_DONE = 3'b100
  } hpb_hstate_t;

  function automatic logic hpb_sel(input logic a, input logic b,
                                   input logic c_n);
    return a & b & ~c_n;
  endfunction : hpb_sel
endpackage : hpb_pkg

// *** hdl/hpb_if.sv ***
`timescale 1ns/10ps
interface hpb_if;
  logic [2:0] reg_select;
  logic [7:0] data_host;
  logic data_host_oe;
  logic [7:0] data_dev;
  logic data_dev_oe;
  logic read_strobe_low;
  logic read_strobe_high;
  logic write_strobe_low;
  logic write_strobe_high;
  logic chip_select_a;
  logic chip_select_b;
  logic chip_select_low;
  logic address_latch_strobe_low;
  logic [7:0] data_bus;

  // Resolved bus level; device wins if both drive at once
  assign data_bus = data_dev_oe ? data_dev :
                    (data_host_oe ? data_host : 8'hFF);

  modport device (
    input reg_select, data_bus, read_strobe_low, read_strobe_high,
    input write_strobe_low, write_strobe_high, chip_select_a,
    input chip_select_b, chip_select_low, address_latch_strobe_low,
    output data_dev, data_dev_oe
  );
  modport host (
    output reg_select, data_host, data_host_oe, read_strobe_low,
    output read_strobe_high, write_strobe_low, write_strobe_high,
    output chip_select_a, chip_select_b, chip_select_low,
    output address_latch_strobe_low,
    input data_bus
  );
endinterface : hpb_if

// *** hdl/hpb_regfile.sv ***
`timescale 1ns/10ps
module hpb_regfile
  import hpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] regs_q [HPB_NUM_REGS];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < HPB_NUM_REGS; i++) begin
        regs_q[i] <= HPB_REG_RESET;
      end
    end else if (wr_en) begin
      regs_q[wr_addr] <= wr_data;
    end
  end

  assign rd_data = regs_q[rd_addr];
endmodule : hpb_regfile

// *** hdl/hpb_device.sv ***
`timescale 1ns/10ps
module hpb_device
  import hpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  hpb_if.device bus,
  input wire logic mode_select,
  output logic [2:0] last_wr_addr,
  output logic [7:0] last_wr_data,
  output logic wr_commit,
  output logic rd_start,
  output logic [8:0] alt_address
);
  logic rdl_q, rdh_q, wrl_q, wrh_q;
  logic [2:0] addr_q;
  logic csa_q, csb_q, csl_q;
  logic [7:0] dout_q;
  logic oe_q;
  logic [2:0] last_wr_addr_q;
  logic [7:0] last_wr_data_q;
  logic wr_commit_q, rd_start_q;
  logic [8:0] alt_address_q;
  logic [7:0] rd_data;

  wire sep_mode = mode_select;
  // Address latch transparent while strobe low, frozen once high
  wire as_open = ~bus.address_latch_strobe_low;
  wire [2:0] addr_eff = as_open ? bus.reg_select : addr_q;
  wire selected = as_open ?
    hpb_sel(bus.chip_select_a, bus.chip_select_b, bus.chip_select_low) :
    hpb_sel(csa_q, csb_q, csl_q);
  // Alternate mode: high strobes are address bits, never strobes
  wire rdh_eff = sep_mode & bus.read_strobe_high;
  wire wrh_eff = sep_mode & bus.write_strobe_high;
  wire rd_act = ~bus.read_strobe_low | rdh_eff;
  wire rdl_fall = rdl_q & ~bus.read_strobe_low;
  wire rdh_rise = ~rdh_q & rdh_eff;
  wire wrl_rise = ~wrl_q & bus.write_strobe_low;
  wire wrh_fall = wrh_q & ~wrh_eff;
  // Alternate mode pins are address lines, so no edge may commit there
  wire commit = (wrl_rise | wrh_fall) & selected & sep_mode;
  wire drive = rd_act & selected & sep_mode;

  hpb_regfile u_regs (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(commit),
    .wr_addr(addr_eff),
    .wr_data(bus.data_bus),
    .rd_addr(addr_eff),
    .rd_data(rd_data)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdl_q <= 1'b1;
      rdh_q <= 1'b0;
      wrl_q <= 1'b1;
      wrh_q <= 1'b0;
    end else begin
      rdl_q <= bus.read_strobe_low;
      rdh_q <= rdh_eff;
      wrl_q <= bus.write_strobe_low;
      wrh_q <= wrh_eff;
    end
  end

  // Latch follows inputs while open so a tied-low strobe works
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_q <= 3'h0;
      csa_q <= 1'b0;
      csb_q <= 1'b0;
      csl_q <= 1'b1;
    end else if (as_open) begin
      addr_q <= bus.reg_select;
      csa_q <= bus.chip_select_a;
      csb_q <= bus.chip_select_b;
      csl_q <= bus.chip_select_low;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dout_q <= 8'h00;
      oe_q <= 1'b0;
      rd_start_q <= 1'b0;
    end else begin
      dout_q <= drive ? rd_data : 8'h00;
      oe_q <= drive;
      rd_start_q <= (rdl_fall | rdh_rise) & selected & sep_mode;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last_wr_addr_q <= 3'h0;
      last_wr_data_q <= 8'h00;
      wr_commit_q <= 1'b0;
      alt_address_q <= 9'h000;
    end else begin
      wr_commit_q <= commit;
      if (commit) begin
        last_wr_addr_q <= addr_eff;
        last_wr_data_q <= bus.data_bus;
      end
      // No pin feeds bit 4 on this port, so it reads as zero
      alt_address_q <= sep_mode ? 9'h000 :
        {bus.write_strobe_high, bus.chip_select_low,
         bus.chip_select_b, bus.chip_select_a, 1'b0,
         bus.read_strobe_high, bus.reg_select};
    end
  end

  assign bus.data_dev = dout_q;
  assign bus.data_dev_oe = oe_q;
  assign last_wr_addr = last_wr_addr_q;
  assign last_wr_data = last_wr_data_q;
  assign wr_commit = wr_commit_q;
  assign rd_start = rd_start_q;
  assign alt_address = alt_address_q;
endmodule : hpb_device

// *** hdl/hpb_host.sv ***
`timescale 1ns/10ps
module hpb_host
  import hpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  hpb_if.host bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_high_pol,
  input wire logic [2:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic req_cs_off,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata
);
  hpb_hstate_t state_q, state_d;
  logic [1:0] cnt_q;
  logic wr_q, hp_q, csoff_q;
  logic [2:0] addr_q;
  logic [7:0] wdata_q, rdata_q;
  logic rsp_q, ready_q;

  wire active = (state_q == HPB_H_PULSE);
  wire drive_d = wr_q & (state_q != HPB_H_IDLE) & (state_q != HPB_H_DONE);
  wire last = (cnt_q == HPB_CNT_W_ZERO);
  wire start = (state_q == HPB_H_IDLE) & req_valid;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      HPB_H_IDLE: if (req_valid) state_d = HPB_H_SETUP;
      HPB_H_SETUP: if (last) state_d = HPB_H_PULSE;
      HPB_H_PULSE: if (last) state_d = HPB_H_HOLD;
      HPB_H_HOLD: if (last) state_d = HPB_H_DONE;
      HPB_H_DONE: state_d = HPB_H_IDLE;
      default: state_d = HPB_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= HPB_H_IDLE;
      cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        unique case (state_d)
          HPB_H_SETUP: cnt_q <= 2'(HPB_SETUP_CYC - 1);
          HPB_H_PULSE: cnt_q <= 2'(HPB_PULSE_CYC - 1);
          HPB_H_HOLD: cnt_q <= 2'(HPB_HOLD_CYC - 1);
          default: cnt_q <= 2'h0;
        endcase
      end else if (!last) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_q <= 1'b0;
      hp_q <= 1'b0;
      csoff_q <= 1'b0;
      addr_q <= 3'h0;
      wdata_q <= 8'h00;
    end else if (start) begin
      wr_q <= req_write;
      hp_q <= req_high_pol;
      csoff_q <= req_cs_off;
      addr_q <= req_addr;
      wdata_q <= req_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 8'h00;
      rsp_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      // Sample late in the pulse, after the device has driven
      if (active & last & ~wr_q) begin
        rdata_q <= bus.data_bus;
      end
      rsp_q <= (state_q == HPB_H_DONE);
      ready_q <= (state_d == HPB_H_IDLE);
    end
  end

  // Only one strobe of a pair toggles; the idle one sits deasserted
  assign bus.read_strobe_low = ~(active & ~wr_q & ~hp_q);
  assign bus.read_strobe_high = active & ~wr_q & hp_q;
  assign bus.write_strobe_low = ~(active & wr_q & ~hp_q);
  assign bus.write_strobe_high = active & wr_q & hp_q;
  // Low select is the one in use; the unused highs sit asserted
  assign bus.chip_select_a = 1'b1;
  assign bus.chip_select_b = 1'b1;
  assign bus.chip_select_low = csoff_q;
  assign bus.address_latch_strobe_low = 1'b0;
  assign bus.reg_select = addr_q;
  assign bus.data_host = wdata_q;
  assign bus.data_host_oe = drive_d;
  assign req_ready = ready_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
endmodule : hpb_host

// *** sim/hpb_properties.sv ***
`timescale 1ns/10ps
module hpb_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mode_select,
  input wire logic data_host_oe,
  input wire logic data_dev_oe,
  input wire logic read_strobe_low,
  input wire logic read_strobe_high,
  input wire logic write_strobe_low,
  input wire logic write_strobe_high,
  input wire logic chip_select_a,
  input wire logic chip_select_b,
  input wire logic chip_select_low,
  input wire logic wr_commit,
  input wire logic rd_start
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic sel;
  logic rd_sel;
  logic go;
  assign sel = chip_select_a & chip_select_b & ~chip_select_low;
  assign rd_sel = sel & (~read_strobe_low | read_strobe_high);
  assign go = sel & mode_select;
  // Drive may outlast the strobe by one cycle, hence depth two
  a_oe_when_read:
    assert property (data_dev_oe |-> $past(rd_sel) || $past(rd_sel, 2))
    else $error("bus driven outside a read");
  a_low_read_drive:
    assert property (go && $fell(read_strobe_low) |-> ##[1:2] data_dev_oe)
    else $error("no drive after low read strobe");
  a_high_read_drive:
    assert property (go && $rose(read_strobe_high) |-> ##[1:2] data_dev_oe)
    else $error("no drive after high read strobe");
  a_low_wr_commit:
    assert property (go && $rose(write_strobe_low) |-> ##[0:2] wr_commit)
    else $error("no commit on low strobe release");
  a_high_wr_commit:
    assert property (go && $fell(write_strobe_high) |-> ##[0:2] wr_commit)
    else $error("no commit on high strobe release");
  a_alt_no_commit:
    assert property ((!mode_select) [*3] |-> !wr_commit)
    else $error("commit in alternate mode");
  a_single_driver:
    assert property (!(data_dev_oe && data_host_oe))
    else $error("both ends drive the data bus");
  a_rd_start_cause:
    assert property (rd_start |-> rd_sel || $past(rd_sel))
    else $error("read start without strobe");
  a_unsel_no_drive:
    assert property (!sel |=> !data_dev_oe)
    else $error("bus driven while unselected");
  a_unsel_no_commit:
    assert property (!sel |=> !wr_commit)
    else $error("commit while unselected");
  a_one_polarity:
    assert property (!((!read_strobe_low && read_strobe_high) ||
                       (!write_strobe_low && write_strobe_high)))
    else $error("both strobe polarities asserted");
  c_low_write: cover property (go && $rose(write_strobe_low));
  c_high_read: cover property (go && $rose(read_strobe_high));
  c_alt_write: cover property ((!mode_select) ##1 $fell(write_strobe_high));
  c_unsel_write: cover property (!sel && $rose(write_strobe_low));
endmodule : hpb_properties

// *** sim/host_parallel_bus_port_tb.sv ***
`timescale 1ns/10ps
module host_parallel_bus_port_tb;
  import hpb_pkg::*;
  typedef struct packed {
    logic [1:0] kind;
    logic [2:0] addr;
    logic [7:0] data;
  } hpb_note_t;
  logic clk_sys, rst, mode_select, req_valid, req_write, req_high_pol;
  logic req_ready, rsp_valid, wr_commit, rd_start, req_cs_off;
  logic [8:0] alt_address;
  logic [2:0] req_addr, last_wr_addr;
  logic [7:0] req_wdata, rsp_rdata, last_wr_data, wd;
  logic [7:0] model [8];
  hpb_note_t q [$];
  hpb_note_t note;
  int seed, i, err_count, n_compared, n_commit, exp_commit, cycles;
  int n_rd, exp_rd, n_alt_wr, n_alt_rd;

  hpb_if bus_if ();
  hpb_host i_hpb_host (.clk_sys(clk_sys), .rst(rst), .bus(bus_if.host),
    .req_valid(req_valid), .req_write(req_write),
    .req_high_pol(req_high_pol), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_cs_off(req_cs_off), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  hpb_device i_hpb_device (.clk_sys(clk_sys), .rst(rst),
    .bus(bus_if.device), .mode_select(mode_select),
    .last_wr_addr(last_wr_addr), .last_wr_data(last_wr_data),
    .wr_commit(wr_commit), .rd_start(rd_start),
    .alt_address(alt_address));
  hpb_properties i_hpb_properties (.clk_sys(clk_sys), .rst(rst),
    .mode_select(mode_select), .data_host_oe(bus_if.data_host_oe),
    .data_dev_oe(bus_if.data_dev_oe),
    .read_strobe_low(bus_if.read_strobe_low),
    .read_strobe_high(bus_if.read_strobe_high),
    .write_strobe_low(bus_if.write_strobe_low),
    .write_strobe_high(bus_if.write_strobe_high),
    .chip_select_a(bus_if.chip_select_a),
    .chip_select_b(bus_if.chip_select_b),
    .chip_select_low(bus_if.chip_select_low),
    .wr_commit(wr_commit), .rd_start(rd_start));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : check

  // Kind 0 read, 1 write, 2 ignored write, 3 unanswered read (bus idle)
  task automatic xfer(input logic w, input logic hp, input logic [2:0] a,
                      input logic [7:0] d, input logic [1:0] k);
    while (req_ready !== 1'b1) @(negedge clk_sys);
    q.push_back(hpb_note_t'{k, a, (k == 2'h0) ? model[a] : d});
    if (k == 2'h1) model[a] = d;
    if (k == 2'h0) exp_rd++;
    req_valid = 1'b1;
    req_write = w;
    req_high_pol = hp;
    req_addr = a;
    req_wdata = d;
    @(negedge clk_sys);
    req_valid = 1'b0;
    @(negedge clk_sys);
  endtask : xfer

  task automatic drain;
    while (q.size() != 0) @(negedge clk_sys);
  endtask : drain

  // Sampled at the falling edge so pulse registers have settled
  always @(negedge clk_sys) begin
    if (!rst && wr_commit === 1'b1) n_commit++;
    if (!rst && rd_start === 1'b1) n_rd++;
    if (!rst && alt_address[8] === 1'b1) n_alt_wr++;
    if (!rst && alt_address[3] === 1'b1) n_alt_rd++;
    if (!rst && rsp_valid === 1'b1) begin
      note = q.pop_front();
      if (note.kind == 2'h0)
        check("read data", note.data, rsp_rdata);
      if (note.kind == 2'h1) begin
        check("write addr", {5'h00, note.addr}, {5'h00, last_wr_addr});
        check("write data", note.data, last_wr_data);
      end
      if (note.kind == 2'h3)
        check("silent read", note.data, rsp_rdata);
      if (note.kind[1] && !mode_select)
        check("alt addr", {5'h0C, note.addr}, alt_address[7:0]);
    end
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    seed = 73;
    cycles = 0;
    rst = 1'b1;
    mode_select = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_high_pol = 1'b0;
    req_addr = 3'h0;
    req_wdata = 8'h00;
    req_cs_off = 1'b0;
    for (i = 0; i < 8; i++) model[i] = HPB_REG_RESET;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    for (i = 0; i < 8; i++) xfer(1'b0, i[0], i[2:0], 8'h00, 2'h0);
    $display("test reset reads done");
    for (i = 0; i < 8; i++) begin
      wd = 8'($random(seed));
      xfer(1'b1, i[0], i[2:0], wd, 2'h1);
      exp_commit++;
    end
    for (i = 7; i >= 0; i--) xfer(1'b0, ~i[0], i[2:0], 8'h00, 2'h0);
    drain();
    $display("test write and read back done");
    // Alternate mode reuses the high strobes as address lines
    mode_select = 1'b0;
    xfer(1'b1, 1'b1, 3'h5, ~model[5], 2'h2);
    xfer(1'b1, 1'b0, 3'h6, ~model[6], 2'h2);
    xfer(1'b0, 1'b1, 3'h3, 8'hFF, 2'h3);
    drain();
    mode_select = 1'b1;
    // Deselected device must neither commit nor answer
    req_cs_off = 1'b1;
    xfer(1'b1, 1'b0, 3'h2, ~model[2], 2'h2);
    xfer(1'b1, 1'b1, 3'h1, ~model[1], 2'h2);
    xfer(1'b0, 1'b0, 3'h2, 8'hFF, 2'h3);
    drain();
    req_cs_off = 1'b0;
    repeat (2) @(negedge clk_sys);
    xfer(1'b0, 1'b1, 3'h5, 8'h00, 2'h0);
    xfer(1'b0, 1'b0, 3'h6, 8'h00, 2'h0);
    xfer(1'b0, 1'b0, 3'h2, 8'h00, 2'h0);
    xfer(1'b0, 1'b1, 3'h1, 8'h00, 2'h0);
    drain();
    check("commit count", 8'(exp_commit), 8'(n_commit));
    check("read starts", 8'(exp_rd), 8'(n_rd));
    check("alt write strobe", 8'(HPB_PULSE_CYC), 8'(n_alt_wr));
    check("alt read strobe", 8'(HPB_PULSE_CYC), 8'(n_alt_rd));
    $display("test alternate mode and deselect done");
    print_verdict();
  end
endmodule : host_parallel_bus_port_tb
